/* File: src/pfp_pkg.sv */
// Constants and types for the parallel FIFO port.
// Function
// - Companion mode with external clock: direction and strobe clock are inputs.
// - Read request stays high while the transmit FIFO holds data.
// - Receive overflow raises an interrupt and later words are dropped.
// - External clock: on rising edge with direction high, drive data out.
// - Read request drops one clock after the edge that reads the last word.
// - External clock: on falling edge with direction low, latch data in.
// - Port clock, direction high: toggle strobe clock while transmit FIFO not empty.
// - Port clock, direction low: trigger starts COUNT+1 word burst, self clears.
// - Port strobe clock is system clock divided by 2, 4, 8 or 16.
// - Port clock, direction low: latch edge select picks rising or falling capture edge.
// - Slave mode: drive data only while strobe low and direction high.
// - Slave mode: capture on strobe rising edge; clock out select ignored.
// - Master mode drives direction, read strobe, clock; writes while FIFO not empty.
// - Master read of COUNT+1 words waits for empty FIFO; trigger self clears.
// - Master cycles timed by programmable integer divider enable.
// - Wait enable clear: ignore wait input, end after wait-state count.
// - Wait enable set: after wait seen high, end strobe after 1+WS periods.
package pfp_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int DIV_W = 8;
    localparam int WS_W = 4;
    localparam int CNT_W = 8;
    localparam logic [1:0] RATIO_RST = 2'h0;

    typedef struct packed {
        logic master_mode_select;
        logic companion_mode_select;
        logic clock_out_select;
        logic latch_edge_select;
        logic wait_enable;
        logic [1:0] clock_ratio;
        logic [DIV_W-1:0] cycle_divider;
        logic [WS_W-1:0] wait_state_count;
        logic [CNT_W-1:0] burst_count;
    } pfp_cfg_s;

    typedef enum logic [2:0] {
        PFP_IDLE,
        PFP_WR_STROBE,
        PFP_RD_STROBE,
        PFP_WAIT_TAIL,
        PFP_GAP
    } pfp_mst_e;
endpackage

/* File: src/pfp_port.sv */
// Parallel FIFO port: slave, companion and master modes with transmit and receive FIFOs.
`timescale 1ns/100ps
module pfp_port #(
    parameter int DEPTH = pfp_pkg::FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire pfp_pkg::pfp_cfg_s cfg_i,
    input wire logic trigger_set_i,
    output logic transfer_trigger_o,
    input wire logic tx_valid_i,
    input wire logic [pfp_pkg::DATA_W-1:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [pfp_pkg::DATA_W-1:0] rx_data_o,
    input wire logic rx_ready_i,
    output logic overflow_irq_o,
    input wire logic overflow_clr_i,
    input wire logic strobe_clock_i,
    output logic strobe_clock_o,
    output logic strobe_clock_oe_o,
    input wire logic write_direction_i,
    output logic write_direction_o,
    output logic write_direction_oe_o,
    output logic read_strobe_o,
    input wire logic wait_input_i,
    output logic read_request_o,
    input wire logic [pfp_pkg::DATA_W-1:0] data_i,
    output logic [pfp_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o
);
    import pfp_pkg::*;

    // The pointers carry one wrap bit above the address; a depth of one leaves the [AW-1:0] address slices with no bits.
    if (DEPTH < 2 || DEPTH > 256) begin : g_depth_check
        $error("DEPTH must be 2..256");
    end

    localparam int AW = $clog2(DEPTH);

    logic [DATA_W-1:0] tx_mem [DEPTH];
    logic [DATA_W-1:0] rx_mem [DEPTH];
    logic [AW:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic sclk_d_r, mclk_r, xdir_r, busy_r, ovf_r, tail_r;
    logic [4:0] div_cnt_r;
    logic [DIV_W-1:0] icnt_r;
    logic [WS_W:0] ws_r;
    logic [CNT_W:0] words_r;
    logic [DATA_W-1:0] dout_r;
    logic oe_r;
    logic first_r;
    pfp_mst_e mst_r;

    wire tx_empty = (tx_wp_r == tx_rp_r);
    wire tx_full = (tx_wp_r[AW-1:0] == tx_rp_r[AW-1:0]) && (tx_wp_r[AW] != tx_rp_r[AW]);
    wire rx_empty = (rx_wp_r == rx_rp_r);
    wire rx_full = (rx_wp_r[AW-1:0] == rx_rp_r[AW-1:0]) && (rx_wp_r[AW] != rx_rp_r[AW]);
    wire mode_slave = !cfg_i.master_mode_select && !cfg_i.companion_mode_select;
    wire mode_ext = cfg_i.companion_mode_select && !cfg_i.clock_out_select && !cfg_i.master_mode_select;
    wire mode_pclk = cfg_i.companion_mode_select && cfg_i.clock_out_select && !cfg_i.master_mode_select;
    wire mode_mst = cfg_i.master_mode_select && !cfg_i.companion_mode_select;
    wire in_clk_sel = mode_pclk ? mclk_r : strobe_clock_i;
    wire clk_rise = in_clk_sel && !sclk_d_r;
    wire clk_fall = !in_clk_sel && sclk_d_r;
    // Ratio 2,4,8,16: toggle every 1,2,4,8 system clocks.
    wire [4:0] half_per = 5'h1 << cfg_i.clock_ratio;
    wire div_tick = (div_cnt_r == half_per - 5'h1);
    wire int_tick = (icnt_r == cfg_i.cycle_divider);
    wire pclk_run = mode_pclk && (write_direction_i ? (!tx_empty || mclk_r) : (busy_r || mclk_r));

    // Data-out and capture events per mode.
    wire ext_read = (mode_ext && clk_rise && write_direction_i) || (mode_pclk && write_direction_i && clk_rise)
        || (mode_slave && clk_fall && write_direction_i);
    wire pc_burst = mode_pclk && !write_direction_i && busy_r;
    // Latch-on-rising takes each word at the rise after it was driven, so the first rise of a burst
    // carries nothing and the final word, which has no later rise, is taken by the system clock.
    wire pc_rise_cap = pc_burst && cfg_i.latch_edge_select && clk_rise && !first_r && !tail_r;
    wire pc_fall_cap = pc_burst && !cfg_i.latch_edge_select && clk_fall;
    wire tail_set = pc_burst && cfg_i.latch_edge_select && clk_fall && (words_r == '0) && !tail_r;
    wire pc_cap = pc_rise_cap || pc_fall_cap || tail_r;
    wire ext_cap = (mode_ext && clk_fall && !write_direction_i) || (mode_slave && clk_rise && !write_direction_i)
        || pc_cap;
    wire m_done = (mst_r == PFP_WAIT_TAIL) && int_tick && (ws_r == '0);
    wire m_cap = m_done && xdir_r == 1'b0 && busy_r;
    // A master write takes its word as the strobe opens, so the data stands for the whole strobe.
    wire m_wr_start = mode_mst && int_tick && (mst_r == PFP_IDLE) && !tx_empty && !(busy_r && !xdir_r);
    wire pop = (ext_read || m_wr_start) && !tx_empty;
    wire cap = ext_cap || m_cap;
    wire push_rx = cap && !rx_full && !ovf_r;
    wire last_pc = (pc_fall_cap && (words_r == '0)) || tail_r;
    wire last_m = m_cap && (words_r == '0);

    assign tx_ready_o = !tx_full;
    assign rx_valid_o = !rx_empty;
    assign rx_data_o = rx_mem[rx_rp_r[AW-1:0]];
    assign read_request_o = !tx_empty;
    assign transfer_trigger_o = busy_r;
    assign overflow_irq_o = ovf_r;
    assign strobe_clock_o = mclk_r;
    assign strobe_clock_oe_o = mode_pclk || mode_mst;
    assign write_direction_o = xdir_r;
    assign write_direction_oe_o = mode_mst;
    assign read_strobe_o = mode_mst && (mst_r != PFP_IDLE) && (mst_r != PFP_GAP) && !xdir_r;
    assign data_o = dout_r;
    assign data_oe_o = oe_r && (mode_slave ? (!strobe_clock_i && write_direction_i) : 1'b1);

    always_ff @(posedge clock_i) begin
        if (tx_valid_i && !tx_full) begin
            tx_mem[tx_wp_r[AW-1:0]] <= tx_data_i;
        end
        if (push_rx) begin
            rx_mem[rx_wp_r[AW-1:0]] <= data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            sclk_d_r <= 1'b0;
            ovf_r <= 1'b0;
            dout_r <= '0;
            oe_r <= 1'b0;
        end else begin
            sclk_d_r <= in_clk_sel;
            tx_wp_r <= tx_wp_r + (AW+1)'(tx_valid_i && !tx_full);
            tx_rp_r <= tx_rp_r + (AW+1)'(pop);
            rx_wp_r <= rx_wp_r + (AW+1)'(push_rx);
            rx_rp_r <= rx_rp_r + (AW+1)'(rx_ready_i && !rx_empty);
            // Set wins over a clear in the same cycle.
            ovf_r <= (cap && rx_full) || (ovf_r && !overflow_clr_i);
            if (pop) begin
                dout_r <= tx_mem[tx_rp_r[AW-1:0]];
            end
            if (pop) begin
                oe_r <= 1'b1;
            end else if (mode_mst ? (mst_r == PFP_GAP || !xdir_r) : !write_direction_i) begin
                oe_r <= 1'b0;
            end
        end
    end

    // Port-driven strobe clock and burst/master sequencing.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt_r <= '0;
            mclk_r <= 1'b0;
            busy_r <= 1'b0;
            tail_r <= 1'b0;
            first_r <= 1'b0;
            words_r <= '0;
            icnt_r <= '0;
            ws_r <= '0;
            xdir_r <= 1'b1;
            mst_r <= PFP_IDLE;
        end else begin
            tail_r <= 1'b0;
            div_cnt_r <= (div_tick || !pclk_run) ? 5'h0 : div_cnt_r + 5'h1;
            if (mode_pclk) begin
                if (pclk_run && div_tick) begin
                    mclk_r <= !mclk_r;
                end
            end else if (mode_mst) begin
                mclk_r <= (mst_r == PFP_WR_STROBE) || (mst_r == PFP_RD_STROBE) || (mst_r == PFP_WAIT_TAIL);
            end else begin
                mclk_r <= 1'b0;
            end
            icnt_r <= int_tick ? '0 : icnt_r + DIV_W'(1);
            if (trigger_set_i && !busy_r) begin
                busy_r <= 1'b1;
                words_r <= {1'b0, cfg_i.burst_count};
            end else if (last_pc) begin
                busy_r <= 1'b0;
            end else if (pc_cap || m_cap) begin
                words_r <= words_r - (CNT_W+1)'(1);
            end
            if (tail_set) begin
                tail_r <= 1'b1;
            end
            if (trigger_set_i && !busy_r) begin
                first_r <= 1'b1;
            end else if (mode_pclk && clk_rise) begin
                first_r <= 1'b0;
            end
            if (last_m) begin
                busy_r <= 1'b0;
            end
            if (int_tick) begin
                unique case (mst_r)
                    PFP_IDLE: begin
                        if (mode_mst && !tx_empty && !(busy_r && xdir_r == 1'b0)) begin
                            xdir_r <= 1'b1;
                            mst_r <= PFP_WR_STROBE;
                        end else if (mode_mst && busy_r && tx_empty) begin
                            xdir_r <= 1'b0;
                            mst_r <= PFP_RD_STROBE;
                        end
                    end
                    PFP_WR_STROBE, PFP_RD_STROBE: begin
                        if (!cfg_i.wait_enable || wait_input_i) begin
                            ws_r <= {1'b0, cfg_i.wait_state_count};
                            mst_r <= PFP_WAIT_TAIL;
                        end
                    end
                    PFP_WAIT_TAIL: begin
                        if (ws_r == '0) begin
                            mst_r <= PFP_GAP;
                        end else begin
                            ws_r <= ws_r - (WS_W+1)'(1);
                        end
                    end
                    PFP_GAP: begin
                        mst_r <= (busy_r && xdir_r == 1'b0) ? PFP_RD_STROBE : PFP_IDLE;
                    end
                endcase
            end
        end
    end

    a_req_tracks_fifo: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        read_request_o == !tx_empty) else $error("read request not tracking FIFO");
    a_req_drop_one: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (pop && tx_rp_r + (AW+1)'(1) == tx_wp_r && !tx_valid_i) |=> !read_request_o)
        else $error("read request late");
    a_ovf_drops: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ovf_r |-> !push_rx) else $error("stored after overflow");
    a_ovf_sets: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (cap && rx_full) |=> ovf_r) else $error("overflow not flagged");
    a_ext_inputs: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        mode_ext |-> !strobe_clock_oe_o && !write_direction_oe_o) else $error("driving inputs");
    a_slave_oe_low: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_slave && (strobe_clock_i || !write_direction_i)) |-> !data_oe_o) else $error("slave oe");
    a_pclk_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_pclk && write_direction_i && tx_empty && !mclk_r) |=> !mclk_r) else $error("clock while empty");
    a_mst_read_wait: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_mst && $rose(read_strobe_o)) |-> $past(tx_empty)) else $error("read before empty");
    a_reset_trigger: assert property (@(posedge clock_i)
        $rose(rst_b_i) |-> !transfer_trigger_o && !read_request_o && !data_oe_o) else $error("reset state");
    a_rx_no_overwrite: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rx_full |-> !push_rx) else $error("stored into full FIFO");
    a_ovf_clears: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ovf_r && overflow_clr_i && !(cap && rx_full)) |=> !ovf_r) else $error("overflow not cleared");
    a_ext_read_oe: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_ext && pop) |=> data_oe_o) else $error("read data not enabled");
    a_ext_capture: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_ext && clk_fall && !write_direction_i && !rx_full && !ovf_r) |-> push_rx) else $error("word lost");

    // Slave and port-clock modes, and the burst trigger held until its last word in port-clock or master mode.
    a_slave_pop_fall: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_slave && pop) |-> clk_fall && write_direction_i) else $error("slave pop edge");
    a_slave_capture: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_slave && clk_rise && !write_direction_i && !rx_full && !ovf_r) |-> push_rx) else $error("slave lost");
    a_pclk_divider: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        mode_pclk |-> div_cnt_r < half_per) else $error("divider out of range");
    a_pclk_parked: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_pclk && !write_direction_i && !busy_r && !mclk_r) |=> !mclk_r) else $error("clock without burst");
    a_tail_single: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tail_r |=> !tail_r) else $error("tail capture repeated");
    a_trigger_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (busy_r && !last_pc && !last_m) |=> busy_r) else $error("trigger cleared early");

    // Master mode.
    a_mst_drives_pins: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        mode_mst |-> strobe_clock_oe_o && write_direction_oe_o) else $error("master pins not driven");
    a_mst_write_oe: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_mst && mst_r == PFP_WR_STROBE) |-> data_oe_o && write_direction_o) else $error("write data off");
    a_mst_read_blocks: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_mst && busy_r && !xdir_r && mst_r != PFP_IDLE) |-> !pop) else $error("write during read");
    a_mst_read_bus: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_mst && read_strobe_o) |-> !data_oe_o) else $error("driving bus while reading");
    a_int_divider: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        mode_mst |-> icnt_r <= cfg_i.cycle_divider) else $error("internal divider overrun");
    a_no_wait_end: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_mst && !cfg_i.wait_enable && int_tick && (mst_r == PFP_WR_STROBE || mst_r == PFP_RD_STROBE))
        |=> mst_r == PFP_WAIT_TAIL) else $error("wait input not ignored");
    a_wait_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (mode_mst && cfg_i.wait_enable && !wait_input_i && int_tick && (mst_r == PFP_WR_STROBE || mst_r == PFP_RD_STROBE))
        |=> $stable(mst_r)) else $error("strobe ended without wait");

    c_ext_read: cover property (@(posedge clock_i) disable iff (!rst_b_i) mode_ext && pop);
    c_overflow: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(ovf_r));
    c_burst_end: cover property (@(posedge clock_i) disable iff (!rst_b_i) $fell(busy_r));
    c_mst_wait: cover property (@(posedge clock_i) disable iff (!rst_b_i) mode_mst && cfg_i.wait_enable && m_done);
    c_slave_write: cover property (@(posedge clock_i) disable iff (!rst_b_i) mode_slave && push_rx);
endmodule // pfp_port

/* File: test/pfp_companion.sv */
// Behavioural companion chip that drives the strobe clock, direction and data bus.
`timescale 1ns/100ps
module pfp_companion (
    input wire logic clock_i,
    output logic strobe_o,
    output logic dir_o,
    output logic [pfp_pkg::DATA_W-1:0] drv_o
);
    import pfp_pkg::*;
    initial begin
        strobe_o = 1'b0;
        dir_o = 1'b1;
        drv_o = 16'h0000;
    end
    // Direction is set while strobe is low and held for the whole period, so it never moves mid-burst.
    task automatic cycle(input logic dir, input logic [DATA_W-1:0] wd);
        @(negedge clock_i);
        dir_o = dir;
        drv_o = wd;
        repeat (3) @(negedge clock_i);
        strobe_o = 1'b1;
        repeat (4) @(negedge clock_i);
        strobe_o = 1'b0;
        repeat (3) @(negedge clock_i);
        // A released bus shows the inverse so a stale capture cannot match by chance.
        drv_o = ~wd;
    endtask
endmodule // pfp_companion

/* File: test/pfp_port_test.sv */
// Self-checking testbench for the parallel FIFO port.
`timescale 1ns/100ps
module pfp_port_test;
    import pfp_pkg::*;
    localparam int DEPTH = 4;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    pfp_cfg_s cfg_i = '0;
    logic trigger_set_i = 1'b0;
    logic tx_valid_i = 1'b0;
    logic [DATA_W-1:0] tx_data_i = 16'h0000;
    logic rx_ready_i = 1'b0;
    logic overflow_clr_i = 1'b0;
    logic wait_input_i = 1'b0;
    logic transfer_trigger_o, tx_ready_o, rx_valid_o, overflow_irq_o, strobe_clock_o, strobe_clock_oe_o;
    logic write_direction_o, write_direction_oe_o, read_strobe_o, read_request_o, data_oe_o;
    logic [DATA_W-1:0] rx_data_o, data_o, data_i, cmp_drv;
    logic strobe_clock_i, write_direction_i, cmp_strobe, cmp_dir;
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    always #12.5 clock_i = ~clock_i;
    assign strobe_clock_i = strobe_clock_oe_o ? strobe_clock_o : cmp_strobe;
    assign write_direction_i = write_direction_oe_o ? write_direction_o : cmp_dir;
    assign data_i = data_oe_o ? data_o : cmp_drv;
    pfp_companion comp (.clock_i, .strobe_o(cmp_strobe), .dir_o(cmp_dir), .drv_o(cmp_drv));
    pfp_port #(.DEPTH(DEPTH)) uut (.clock_i, .rst_b_i, .cfg_i, .trigger_set_i, .transfer_trigger_o, .tx_valid_i,
        .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .overflow_irq_o, .overflow_clr_i,
        .strobe_clock_i, .strobe_clock_o, .strobe_clock_oe_o, .write_direction_i, .write_direction_o,
        .write_direction_oe_o, .read_strobe_o, .wait_input_i, .read_request_o, .data_i, .data_o, .data_oe_o);
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic push(input logic [DATA_W-1:0] w);
        @(negedge clock_i);
        tx_valid_i = 1'b1;
        tx_data_i = w;
        @(negedge clock_i);
        tx_valid_i = 1'b0;
        @(negedge clock_i);
    endtask
    task automatic t_reset;
        check(16'(read_request_o), 16'h0000);
        check(16'(data_oe_o), 16'h0000);
        check(16'(transfer_trigger_o), 16'h0000);
        check(16'(rx_valid_o), 16'h0000);
    endtask
    task automatic t_read;
        cfg_i.companion_mode_select = 1'b1;
        for (int i = 0; i < 3; i++) push(16'hC350 + 16'(i));
        check(16'(read_request_o), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            if (read_request_o === 1'b1) comp.cycle(1'b1, 16'h0000);
            check(data_o, 16'hC350 + 16'(i));
            check(16'(data_oe_o), 16'h0001);
        end
        check(16'(read_request_o), 16'h0000);
    endtask
    task automatic t_write;
        for (int i = 0; i < DEPTH + 2; i++) comp.cycle(1'b0, 16'h5A00 + 16'(i));
        check(16'(overflow_irq_o), 16'h0001);
        @(negedge clock_i);
        rx_ready_i = 1'b1;
        for (int i = 0; i < DEPTH; i++) begin
            check(rx_data_o, 16'h5A00 + 16'(i));
            @(negedge clock_i);
        end
        rx_ready_i = 1'b0;
        check(16'(rx_valid_o), 16'h0000);
        overflow_clr_i = 1'b1;
        @(negedge clock_i);
        overflow_clr_i = 1'b0;
    endtask
    task automatic edge_wait(input logic v);
        while (strobe_clock_o !== v && n < 200) begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task automatic t_slave;
        cfg_i = '0;
        push(16'hB200);
        comp.cycle(1'b1, 16'h0000);
        check(data_o, 16'hB200);
        check(16'(data_oe_o), 16'h0001);
        comp.cycle(1'b0, 16'hB2A5);
        check(16'(data_oe_o), 16'h0000);
        check(rx_data_o, 16'hB2A5);
        rx_ready_i = 1'b1;
        @(negedge clock_i);
        rx_ready_i = 1'b0;
        check(16'(rx_valid_o), 16'h0000);
    endtask
    task automatic t_portclk;
        cfg_i = '0;
        cfg_i.companion_mode_select = 1'b1;
        cfg_i.clock_out_select = 1'b1;
        for (int r = 0; r < 4; r++) begin
            // Direction low parks the strobe clock while both words are loaded.
            comp.dir_o = 1'b0;
            cfg_i.clock_ratio = 2'(r);
            push(16'h3C00 + 16'(r));
            push(16'h3C10 + 16'(r));
            comp.dir_o = 1'b1;
            n = 0;
            edge_wait(1'b1);
            n = 0;
            edge_wait(1'b0);
            edge_wait(1'b1);
            check(16'(n), 16'(2 << r));
            n = 0;
            while (read_request_o !== 1'b0 && n < 200) begin
                @(negedge clock_i);
                n++;
            end
            repeat (40) @(negedge clock_i);
            check(data_o, 16'h3C10 + 16'(r));
        end
    endtask
    task automatic t_master;
        cfg_i = '0;
        cfg_i.master_mode_select = 1'b1;
        cfg_i.cycle_divider = 8'h01;
        cfg_i.wait_state_count = 4'h1;
        cfg_i.burst_count = 8'h01;
        push(16'hA100);
        push(16'hA101);
        repeat (40) @(negedge clock_i);
        check(16'(read_request_o), 16'h0000);
        check(data_o, 16'hA101);
        comp.drv_o = 16'h7E01;
        trigger_set_i = 1'b1;
        @(negedge clock_i);
        trigger_set_i = 1'b0;
        check(16'(transfer_trigger_o), 16'h0001);
        n = 0;
        while (transfer_trigger_o !== 1'b0 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        check(16'(transfer_trigger_o), 16'h0000);
        rx_ready_i = 1'b1;
        for (int i = 0; i < 2; i++) begin
            check(rx_data_o, 16'h7E01);
            check(16'(rx_valid_o), 16'h0001);
            @(negedge clock_i);
        end
        rx_ready_i = 1'b0;
        check(16'(rx_valid_o), 16'h0000);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock_i);
        rst_b_i = 1'b1;
        t_reset();
        t_read();
        t_write();
        t_slave();
        t_portclk();
        t_master();
        tally_and_finish();
    end
    // The whole sequence needs a few hundred clocks; this bound is ample.
    initial begin
        #500us;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // pfp_port_test
